// ### core/mio_defines.svh
/*
  register offsets, reset values and bus constants of the port block.
  assumes byte addressing on an 8-bit slice of the register bus address.
*/
`ifndef MIO_DEFINES_SVH
`define MIO_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define OFF_PORT0          8'h00
`define OFF_PORT1          8'h04
`define OFF_PORT2          8'h08
`define OFF_PORT3          8'h0C
`define OFF_PIN0           8'h10
`define OFF_PIN1           8'h14
`define OFF_PIN2           8'h18
`define OFF_PIN3           8'h1C
`define OFF_SYSCTRL        8'h20
`define OFF_P1_ANALOG      8'h24
`define OFF_P3_ANALOG      8'h28

// ****************************************
// fields and reset values
// ****************************************
`define REMAP_BIT          0
`define LATCH_RESET        8'hFF
`define ANALOG_RESET       4'hF
`define SYSCTRL_RESET      1'b0
`define ALL_ONES           8'hFF
`define ALL_ZEROS          8'h00

// ****************************************
// bus answers
// ****************************************
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// ### core/mio_pkg.sv
/*
  types shared by the port block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package mio_pkg;

  // ****************************************
  // pin drive carrier
  // ****************************************
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  typedef logic [7:0] byte_t;

endpackage

// ### core/multifunction_io_ports.sv
/*
  four 8-bit port latches with pin drive, alternate functions, analog
  selects and external bus takeover, reached over an AXI4-Lite slave.
  assumes pins are asynchronous and synchronised here; the cpu, timers,
  capture/compare unit and bus sequencer run on core_clk.
*/
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
// Overview of operation
// - eight analog inputs on P1.0-3, P3.2-5
// - reset disables analog, pins digital inputs
// - clearing select bit makes pin analog
// - analog selects reachable only with remap set
// - push-pull only while serving compare output
// - port 1 upper bits carry capture_compare_unit channels
// - P1.0 timer2 count, P1.1 timer2 trigger
// - P3.6/P3.7 strobes, P3.6 ext_interrupt2_input, serial
// - P3.2-5 interrupts, gates, timer count inputs
// - latch loads bus data on write strobe
// - latch read returns stored latch value
// - pin read returns sampled pin level
// - every line independently input or output
// - port 0 open drain, pullup only bus
// - port 0 latch one floats pin
// - alternate function passes only with latch one
// - reset sets every port latch to one
// - ports 0/2 switched to external bus
// - bus mode: port2 kept, port0 all ones
// - 16-bit cycle: port2 drives ones strongly
// - expansion ram moves make no bus cycle
// - latch reaches pin next machine cycle
`timescale 1ns/1ps
`include "mio_defines.svh"

module multifunction_io_ports
  import mio_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // port pins
  input  wire logic [7:0]  p0_pin_in,
  input  wire logic [7:0]  p1_pin_in,
  input  wire logic [7:0]  p2_pin_in,
  input  wire logic [7:0]  p3_pin_in,
  output pin_drive_t       p0_drive,
  output pin_drive_t       p1_drive,
  output pin_drive_t       p2_drive,
  output pin_drive_t       p3_drive,
  output logic [7:0]       analog_enable,
  // external bus control
  input  wire logic        external_access_pin,
  input  wire logic        code_fetch_req,
  input  wire logic        pc_beyond_rom,
  input  wire logic        external_data_move,
  input  wire logic        internal_expansion_ram_hit,
  input  wire logic        wide_address,
  input  wire logic [7:0]  bus_addr_high,
  input  wire logic [7:0]  bus_p0_out,
  input  wire logic        bus_p0_drive,
  output logic             ext_bus_active,
  // alternate outputs into the pins
  input  wire logic [5:0]  compare_out_en,
  input  wire logic [5:0]  compare_out_val,
  input  wire logic        serial_rx_out,
  input  wire logic        serial_tx_out,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  // alternate inputs from the pins
  output logic             timer2_count_input,
  output logic             timer2_trigger_input,
  output logic [2:0]       capture_compare_unit_channel_in,
  output logic             serial_rx_in,
  output logic             ext_int0_in,
  output logic             ext_int1_in,
  output logic             timer0_count_in,
  output logic             timer1_count_in,
  output logic             ext_interrupt2_input
);

  // ****************************************
  // reset release
  // ****************************************
  logic       rst_s1_q;
  logic       rst_n_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  // first stage feeds only the second stage
  byte_t      pin_s1_q [4];
  byte_t      pin_q    [4];
  logic       ea_s1_q;
  logic       ea_q;

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < 4; i++) begin
        pin_s1_q[i] <= `ALL_ONES;
        pin_q[i]    <= `ALL_ONES;
      end
      ea_s1_q <= 1'b1;
      ea_q    <= 1'b1;
    end else begin
      pin_s1_q[0] <= p0_pin_in;
      pin_s1_q[1] <= p1_pin_in;
      pin_s1_q[2] <= p2_pin_in;
      pin_s1_q[3] <= p3_pin_in;
      for (int i = 0; i < 4; i++) begin
        pin_q[i] <= pin_s1_q[i];
      end
      ea_s1_q <= external_access_pin;
      ea_q    <= ea_s1_q;
    end
  end

  // ****************************************
  // axi4-lite handshakes
  // ****************************************
  logic       aw_have_q;
  logic       w_have_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic       w_lane0_q;
  logic       wr_fire;
  logic       ar_fire;
  logic       wr_hit;
  logic [7:0] rd_byte;
  logic       rd_hit;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= `ALL_ZEROS;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (wr_fire) aw_have_q <= 1'b0;
      s_axi_awready <= !aw_have_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      w_have_q     <= 1'b0;
      w_data_q     <= `ALL_ZEROS;
      w_lane0_q    <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q     <= 1'b1;
      w_data_q     <= s_axi_wdata[7:0];
      w_lane0_q    <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else begin
      if (wr_fire) w_have_q <= 1'b0;
      s_axi_wready <= !w_have_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  byte_t      latch_q [4];
  logic       remap_q;
  logic [3:0] p1_sel_q;
  logic [3:0] p3_sel_q;
  logic       bus_sel_q;
  logic       wr_en;

  assign wr_en = wr_fire && w_lane0_q;

  always_comb begin
    unique case (aw_addr_q)
      `OFF_PORT0, `OFF_PORT1, `OFF_PORT2, `OFF_PORT3: wr_hit = 1'b1;
      `OFF_SYSCTRL:                                   wr_hit = 1'b1;
      `OFF_P1_ANALOG, `OFF_P3_ANALOG:                 wr_hit = remap_q;
      default:                                        wr_hit = 1'b0;
    endcase
  end

  // port 0 refill during bus use wins over a cpu write
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < 4; i++) begin
        latch_q[i] <= `LATCH_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_en && aw_addr_q == (`OFF_PORT0 + 8'(4 * i))) begin
          latch_q[i] <= w_data_q;
        end
      end
      if (bus_sel_q) latch_q[0] <= `ALL_ONES;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      remap_q  <= `SYSCTRL_RESET;
      p1_sel_q <= `ANALOG_RESET;
      p3_sel_q <= `ANALOG_RESET;
    end else if (wr_en) begin
      if (aw_addr_q == `OFF_SYSCTRL) remap_q <= w_data_q[`REMAP_BIT];
      if (remap_q && aw_addr_q == `OFF_P1_ANALOG) p1_sel_q <= w_data_q[3:0];
      if (remap_q && aw_addr_q == `OFF_P3_ANALOG) p3_sel_q <= w_data_q[5:2];
    end
  end

  // ****************************************
  // digital view of the pins
  // ****************************************
  // analog pins read as zero so stray levels never look like data
  byte_t      an1;
  byte_t      an3;
  byte_t      din [4];

  assign an1    = {4'h0, ~p1_sel_q};
  assign an3    = {2'b00, ~p3_sel_q, 2'b00};
  assign din[0] = pin_q[0];
  assign din[1] = pin_q[1] & ~an1;
  assign din[2] = pin_q[2];
  assign din[3] = pin_q[3] & ~an3;

  // ****************************************
  // register read
  // ****************************************
  always_comb begin
    rd_byte = `ALL_ZEROS;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      `OFF_PORT0:     rd_byte = latch_q[0];
      `OFF_PORT1:     rd_byte = latch_q[1];
      `OFF_PORT2:     rd_byte = latch_q[2];
      `OFF_PORT3:     rd_byte = latch_q[3];
      `OFF_PIN0:      rd_byte = din[0];
      `OFF_PIN1:      rd_byte = din[1];
      `OFF_PIN2:      rd_byte = din[2];
      `OFF_PIN3:      rd_byte = din[3];
      `OFF_SYSCTRL:   rd_byte = {7'h00, remap_q};
      `OFF_P1_ANALOG: begin
        rd_byte = remap_q ? {4'h0, p1_sel_q} : `ALL_ZEROS;
        rd_hit  = remap_q;
      end
      `OFF_P3_ANALOG: begin
        rd_byte = remap_q ? {2'b00, p3_sel_q, 2'b00} : `ALL_ZEROS;
        rd_hit  = remap_q;
      end
      default:        rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // external bus takeover
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_sel_q <= 1'b0;
    end else begin
      bus_sel_q <= (code_fetch_req && (!ea_q || pc_beyond_rom)) ||
                   (external_data_move && !internal_expansion_ram_hit);
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // drives are registered, so a latch change shows one cycle later
  byte_t      cmp_en;
  byte_t      alt1;
  byte_t      alt3;
  byte_t      push1;
  byte_t      drv1;
  byte_t      drv3;
  pin_drive_t p0_d;
  pin_drive_t p1_d;
  pin_drive_t p2_d;
  pin_drive_t p3_d;

  assign cmp_en = {compare_out_en, 2'b00};
  assign alt1   = {compare_out_val, 2'b11} | ~cmp_en;
  assign alt3   = {read_strobe_n, write_strobe_n, 4'hF, serial_tx_out, serial_rx_out};
  assign push1  = cmp_en & latch_q[1];
  assign drv1   = latch_q[1] & alt1;
  assign drv3   = latch_q[3] & alt3;

  always_comb begin
    if (bus_sel_q) begin
      p0_d.out = bus_p0_out;
      p0_d.oe  = bus_p0_drive ? `ALL_ONES : `ALL_ZEROS;
    end else begin
      p0_d.out = `ALL_ZEROS;
      p0_d.oe  = ~latch_q[0];
    end
    if (bus_sel_q && wide_address) begin
      p2_d.out = bus_addr_high;
      p2_d.oe  = `ALL_ONES;
    end else begin
      p2_d.out = `ALL_ZEROS;
      p2_d.oe  = ~latch_q[2];
    end
    p1_d.out = drv1 & push1;
    p1_d.oe  = (push1 | ~drv1) & ~an1;
    p3_d.out = `ALL_ZEROS;
    p3_d.oe  = ~drv3 & ~an3;
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      p0_drive       <= '0;
      p1_drive       <= '0;
      p2_drive       <= '0;
      p3_drive       <= '0;
      analog_enable  <= `ALL_ZEROS;
      ext_bus_active <= 1'b0;
    end else begin
      p0_drive       <= p0_d;
      p1_drive       <= p1_d;
      p2_drive       <= p2_d;
      p3_drive       <= p3_d;
      analog_enable  <= {an3[5:2], an1[3:0]};
      ext_bus_active <= bus_sel_q;
    end
  end

  // ****************************************
  // alternate inputs
  // ****************************************
  // sampled once per cycle, so pulses shorter than a cycle may be missed
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      timer2_count_input   <= 1'b1;
      timer2_trigger_input <= 1'b1;
      capture_compare_unit_channel_in    <= 3'b111;
      serial_rx_in         <= 1'b1;
      ext_int0_in          <= 1'b1;
      ext_int1_in          <= 1'b1;
      timer0_count_in      <= 1'b1;
      timer1_count_in      <= 1'b1;
      ext_interrupt2_input <= 1'b1;
    end else begin
      timer2_count_input   <= din[1][0] & latch_q[1][0];
      timer2_trigger_input <= din[1][1] & latch_q[1][1];
      capture_compare_unit_channel_in    <= {din[1][6], din[1][4], din[1][2]} &
                              {latch_q[1][6], latch_q[1][4], latch_q[1][2]};
      serial_rx_in         <= din[3][0] & latch_q[3][0];
      ext_int0_in          <= din[3][2] & latch_q[3][2];
      ext_int1_in          <= din[3][3] & latch_q[3][3];
      timer0_count_in      <= din[3][4] & latch_q[3][4];
      timer1_count_in      <= din[3][5] & latch_q[3][5];
      ext_interrupt2_input <= din[3][6] & latch_q[3][6];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_q);

  sequence latch_read_req;
    ar_fire && s_axi_araddr == `OFF_PORT1;
  endsequence

  a_latch_write: assert property (wr_en && aw_addr_q == `OFF_PORT1 |=> latch_q[1] == $past(w_data_q))
    else $error("port latch did not load written data");
  a_latch_read: assert property (latch_read_req |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(latch_q[1]))
    else $error("latch read returned wrong value");
  a_remap_gate: assert property (!remap_q && wr_fire |=> $stable(p1_sel_q) && $stable(p3_sel_q))
    else $error("analog select changed without remap");
  a_p0_bus_ones: assert property (bus_sel_q |=> latch_q[0] == `ALL_ONES)
    else $error("port 0 latch not refilled during bus use");
  a_p0_open_drain: assert property (!bus_sel_q |=> p0_drive.out == `ALL_ZEROS)
    else $error("port 0 drove high as general output");
  a_p0_float: assert property (!bus_sel_q && latch_q[0][0] |=> !p0_drive.oe[0])
    else $error("port 0 pin driven with latch one");
  a_forced_low: assert property (!latch_q[3][1] |=> p3_drive.oe[1] && !p3_drive.out[1])
    else $error("latch zero did not force pin low");
  a_push_pull: assert property (compare_out_en[0] && latch_q[1][2] && p1_sel_q[2] |=>
                                p1_drive.oe[2] && p1_drive.out[2] == $past(compare_out_val[0]))
    else $error("compare output not push-pull");
  a_p2_strong: assert property (bus_sel_q && wide_address |=> p2_drive.oe == `ALL_ONES)
    else $error("port 2 not driving address strongly");
  a_pin_timing: assert property ($changed(latch_q[2]) && !bus_sel_q |=> p2_drive.oe == ~$past(latch_q[2]))
    else $error("port 2 latch change not on pin next cycle");
  a_internal_expansion_ram_no_bus: assert property (external_data_move && internal_expansion_ram_hit && !code_fetch_req |=>
                                  !bus_sel_q)
    else $error("expansion ram move started a bus cycle");

endmodule

// ### dv/pin_partner.sv
/*
  pin partner: resolves the 32 port pins from the block drives and
  from external drivers. assumes external values change only on clock edges.
*/
`timescale 1ns/1ps

module pin_partner
  import mio_pkg::*;
(
  // clock
  input  wire logic             core_clk,
  // block drives, index 0 is port 0
  input  wire pin_drive_t [3:0] drv,
  // external circuitry
  input  wire logic [31:0]      ext_val,
  input  wire logic [31:0]      ext_en,
  // resolved pin levels
  output logic [31:0]           pins
);
  logic float_q = 1'b0;

  // a floating port 0 line toggles so a stale level never passes as valid
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (drv[i/8].oe[i%8]) begin
        pins[i] = drv[i/8].out[i%8];
      end else if (ext_en[i]) begin
        pins[i] = ext_val[i];
      end else begin
        pins[i] = (i < 8) ? float_q : 1'b1;
      end
    end
  end
endmodule

// ### dv/testbench.sv
/*
  self-checking bench of the port block: register bus master, pin partner.
  assumes the block answers within the watchdog ceiling of 5000 cycles.
*/
`timescale 1ns/1ps
`include "mio_defines.svh"

module testbench
  import mio_pkg::*;
;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_bus_active;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, pins, ext_val = 32'h0000_0000, ext_en = 32'h0000_0000;
  logic [7:0] p0_pin_in, p1_pin_in, p2_pin_in, p3_pin_in, analog_enable, v;
  logic [7:0] bus_addr_high = 8'h00, bus_p0_out = 8'h00;
  logic external_access_pin = 1, code_fetch_req = 0, pc_beyond_rom = 0, external_data_move = 0;
  logic internal_expansion_ram_hit = 0, wide_address = 0, bus_p0_drive = 0;
  logic [5:0] compare_out_en = 6'h00, compare_out_val = 6'h00;
  logic serial_rx_out = 1, serial_tx_out = 1, write_strobe_n = 1, read_strobe_n = 1;
  logic timer2_count_input, ext_int0_in, ext_interrupt2_input;
  logic timer2_trigger_input, serial_rx_in, ext_int1_in, timer0_count_in, timer1_count_in;
  logic [2:0] capture_compare_unit_channel_in;
  pin_drive_t p0_drive, p1_drive, p2_drive, p3_drive;
  pin_drive_t [3:0] drv_all;
  int err_count = 0, cmp_count = 0, cycles = 0;

  assign drv_all = {p3_drive, p2_drive, p1_drive, p0_drive};
  assign {p3_pin_in, p2_pin_in, p1_pin_in, p0_pin_in} = pins;

  multifunction_io_ports DUT (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .p0_pin_in, .p1_pin_in, .p2_pin_in, .p3_pin_in, .p0_drive, .p1_drive, .p2_drive, .p3_drive,
    .analog_enable, .external_access_pin, .code_fetch_req, .pc_beyond_rom, .external_data_move,
    .internal_expansion_ram_hit, .wide_address, .bus_addr_high, .bus_p0_out, .bus_p0_drive,
    .ext_bus_active, .compare_out_en, .compare_out_val, .serial_rx_out, .serial_tx_out,
    .write_strobe_n, .read_strobe_n, .timer2_count_input, .timer2_trigger_input, .capture_compare_unit_channel_in,
    .serial_rx_in, .ext_int0_in, .ext_int1_in, .timer0_count_in, .timer1_count_in,
    .ext_interrupt2_input
  );

  pin_partner partner (.core_clk(core_clk), .drv(drv_all), .ext_val(ext_val), .ext_en(ext_en), .pins(pins));

  // ****************************************
  // clock, watchdog, verdict
  // ****************************************
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // quasi-bidirectional and open drain: a latch zero pulls low, a one releases
  function automatic logic [15:0] exp_drive(input logic [7:0] latch);
    return {8'h00, ~latch};
  endfunction

  task automatic chk_drive(input int p, input logic [7:0] latch);
    chk("drive", exp_drive(latch), {drv_all[p].out & drv_all[p].oe, drv_all[p].oe});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 0;
    while (!b_t) begin
      @(negedge core_clk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      b_t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", er, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 0;
    while (!r_t) begin
      @(negedge core_clk);
      ar_t = s_axi_arvalid & s_axi_arready;
      r_t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h0, ed}, d);
    chk("rresp", er, r);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(27));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      rd(`OFF_PORT0 + 8'(i * 4), 8'hFF, `RESP_OKAY);
      chk_drive(i, 8'hFF);
    end
    chk("analog", 8'h00, analog_enable);
    $display("test reset done");
    // all zeros, then 8'hA5, then random latch values on every port
    for (int n = 0; n < 12; n++) begin
      v = (n < 4) ? 8'h00 : (n < 8) ? 8'hA5 : 8'($urandom);
      wr(`OFF_PORT0 + 8'((n % 4) * 4), 32'({$urandom, v}), `RESP_OKAY);
      settle(1);
      chk_drive(n % 4, v);
      rd(`OFF_PORT0 + 8'((n % 4) * 4), v, `RESP_OKAY);
    end
    $display("test latch done");
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_PORT0 + 8'(i * 4), 32'h0000_00FF, `RESP_OKAY);
    end
    ext_en <= 32'hFFFF_FFFF;
    ext_val <= $urandom;
    settle(5);
    for (int i = 0; i < 4; i++) begin
      rd(`OFF_PIN0 + 8'(i * 4), ext_val[i*8 +: 8], `RESP_OKAY);
    end
    chk("t2 count", ext_val[8], timer2_count_input);
    chk("int0", ext_val[26], ext_int0_in);
    chk("ext_interrupt2_input", ext_val[30], ext_interrupt2_input);
    chk("t2 trig", ext_val[9], timer2_trigger_input);
    chk("capture_compare_unit in", {ext_val[14], ext_val[12], ext_val[10]}, capture_compare_unit_channel_in);
    chk("rx in", ext_val[24], serial_rx_in);
    chk("int1", ext_val[27], ext_int1_in);
    chk("t0 count", ext_val[28], timer0_count_in);
    chk("t1 count", ext_val[29], timer1_count_in);
    $display("test pin read done");
    wr(`OFF_P1_ANALOG, 32'h0000_000E, `RESP_SLVERR);
    rd(`OFF_P3_ANALOG, 8'h00, `RESP_SLVERR);
    wr(`OFF_SYSCTRL, 32'h0000_0001, `RESP_OKAY);
    wr(`OFF_P1_ANALOG, 32'h0000_000E, `RESP_OKAY);
    wr(`OFF_P3_ANALOG, 32'h0000_0038, `RESP_OKAY);
    settle(5);
    chk("analog", 8'h11, analog_enable);
    chk("t2 analog", 1'b0, timer2_count_input);
    rd(`OFF_PIN1, ext_val[15:8] & 8'hFE, `RESP_OKAY);
    wr(`OFF_P1_ANALOG, 32'h0000_000F, `RESP_OKAY);
    wr(`OFF_P3_ANALOG, 32'h0000_003C, `RESP_OKAY);
    rd(8'h2C, 8'h00, `RESP_SLVERR);
    wr(8'h2C, 32'h0000_0000, `RESP_SLVERR);
    settle(1);
    chk("analog", 8'h00, analog_enable);
    $display("test analog done");
    @(posedge core_clk);
    compare_out_en <= 6'h01;
    compare_out_val <= 6'h01;
    settle(3);
    chk("cc0 drive", 2'b11, {p1_drive.out[2], p1_drive.oe[2]});
    wr(`OFF_PORT1, 32'h0000_00FB, `RESP_OKAY);
    settle(3);
    chk("cc0 gated", 2'b01, {p1_drive.out[2], p1_drive.oe[2]});
    @(posedge core_clk);
    write_strobe_n <= 1'b0;
    settle(2);
    chk("wr strobe", 2'b01, {p3_drive.out[6], p3_drive.oe[6]});
    @(posedge core_clk);
    write_strobe_n <= 1'b1;
    $display("test compare done");
    wr(`OFF_PORT0, 32'h0000_003C, `RESP_OKAY);
    external_data_move <= 1'b1;
    internal_expansion_ram_hit <= 1'b1;
    settle(4);
    chk("bus", 1'b0, ext_bus_active);
    chk("p0 free", 16'h00C3, p0_drive);
    @(posedge core_clk);
    internal_expansion_ram_hit <= 1'b0;
    wide_address <= 1'b1;
    bus_addr_high <= 8'($urandom);
    bus_p0_out <= 8'h5A;
    bus_p0_drive <= 1'b1;
    settle(4);
    chk("bus", 1'b1, ext_bus_active);
    chk("p2 addr", {bus_addr_high, 8'hFF}, p2_drive);
    chk("p0 bus", 16'h5AFF, p0_drive);
    @(posedge core_clk);
    external_data_move <= 1'b0;
    code_fetch_req <= 1'b1;
    settle(4);
    chk("bus", 1'b0, ext_bus_active);
    @(posedge core_clk);
    external_access_pin <= 1'b0;
    settle(5);
    chk("bus ea", 1'b1, ext_bus_active);
    @(posedge core_clk);
    external_access_pin <= 1'b1;
    pc_beyond_rom <= 1'b1;
    settle(5);
    chk("bus pc", 1'b1, ext_bus_active);
    @(posedge core_clk);
    code_fetch_req <= 1'b0;
    settle(4);
    chk("bus", 1'b0, ext_bus_active);
    rd(`OFF_PORT0, 8'hFF, `RESP_OKAY);
    rd(`OFF_PORT2, 8'hFF, `RESP_OKAY);
    $display("test bus done");
    give_verdict();
  end
endmodule
